//--- core/imbp_master.sv
// Byte-oriented two-wire bus master with four byte registers
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module imbp_master (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic [1:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	output logic tx_irq_out,
	output logic rx_irq_out,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out
);
	typedef struct packed {
		imbp_pkg::imbp_state_t state;
		logic [1:0] phase;
		logic [2:0] bitcnt;
		logic [7:0] shift;
		logic is_read;
		logic rx_mode;
		logic addr_phase;
		logic ack_fail;
		logic bus_open;
		logic tx_pend;
		logic rd_more;
		logic err_pend;
		logic stop_after_write;
		logic stop_after_read;
		logic tx_empty_irq_enable;
		logic tx_empty_flag;
		logic fast;
		logic bus_error;
		logic rx_ready_irq_enable;
		logic rx_full_flag;
		logic [7:0] target_address;
		logic [7:0] receive_byte;
		logic [7:0] transmit_byte;
		logic [7:0] rdata;
		logic scl_oe;
		logic sda_oe;
		logic tx_irq;
		logic rx_irq;
	} imbp_master_t;

	imbp_master_t s_q;
	imbp_master_t s_d;
	logic tick;
	logic [1:0] pins_sync;
	logic scl_hi;
	logic sda_hi;
	logic adv;
	logic [7:0] status_view;

	imbp_sync #(
		.WIDTH(2)
	) u_sync (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.async_in({scl_in, sda_in}),
		.sync_out(pins_sync)
	);

	imbp_tick u_tick (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.fast_in(s_q.fast),
		.tick_out(tick)
	);

	assign scl_hi = pins_sync[1];
	assign sda_hi = pins_sync[0];
	// A target holding the clock low stalls the sample phase
	assign adv = tick && !(s_q.phase == imbp_pkg::PH_SAMPLE && !scl_hi);

	always_comb begin
		status_view = 8'h00;
		status_view[imbp_pkg::BIT_STOP_WR] = s_q.stop_after_write;
		status_view[imbp_pkg::BIT_STOP_RD] = s_q.stop_after_read;
		status_view[imbp_pkg::BIT_TX_IE] = s_q.tx_empty_irq_enable;
		status_view[imbp_pkg::BIT_TX_EMPTY] = s_q.tx_empty_flag;
		status_view[imbp_pkg::BIT_FAST] = s_q.fast;
		status_view[imbp_pkg::BIT_ERROR] = s_q.bus_error;
		status_view[imbp_pkg::BIT_RX_IE] = s_q.rx_ready_irq_enable;
		status_view[imbp_pkg::BIT_RX_FULL] = s_q.rx_full_flag;
	end

	always_comb begin
		s_d = s_q;
		s_d.rdata = 8'h00;
		// Register port first, so hardware sets below win over clears
		if (reg_wr_in) begin
			case (reg_addr_in)
				imbp_pkg::REG_STATUS: begin
					s_d.stop_after_write = reg_wdata_in[imbp_pkg::BIT_STOP_WR];
					s_d.stop_after_read = reg_wdata_in[imbp_pkg::BIT_STOP_RD];
					s_d.tx_empty_irq_enable = reg_wdata_in[imbp_pkg::BIT_TX_IE];
					s_d.fast = reg_wdata_in[imbp_pkg::BIT_FAST];
					s_d.rx_ready_irq_enable = reg_wdata_in[imbp_pkg::BIT_RX_IE];
					if (reg_wdata_in[imbp_pkg::BIT_ERROR]) begin
						s_d.bus_error = 1'b0;
					end
				end
				imbp_pkg::REG_ADDRESS: begin
					s_d.target_address = reg_wdata_in;
				end
				imbp_pkg::REG_TRANSMIT: begin
					s_d.transmit_byte = reg_wdata_in;
					s_d.tx_empty_flag = 1'b0;
					s_d.tx_pend = 1'b1;
				end
				default: begin
				end
			endcase
		end
		if (reg_rd_in) begin
			case (reg_addr_in)
				imbp_pkg::REG_STATUS: s_d.rdata = status_view;
				imbp_pkg::REG_ADDRESS: s_d.rdata = s_q.target_address;
				imbp_pkg::REG_RECEIVE: begin
					s_d.rdata = s_q.receive_byte;
					s_d.rx_full_flag = 1'b0;
				end
				default: s_d.rdata = 8'h00;
			endcase
		end

		// Requests are taken only while the bus engine sits between bytes
		case (s_q.state)
			imbp_pkg::ST_IDLE: begin
				if (s_q.tx_pend) begin
					s_d.tx_pend = 1'b0;
					s_d.is_read = s_q.target_address[imbp_pkg::BIT_DIR];
					s_d.state = imbp_pkg::ST_START;
					s_d.phase = imbp_pkg::PH_DRIVE;
				end
			end
			imbp_pkg::ST_HOLD: begin
				if (s_q.tx_pend) begin
					s_d.tx_pend = 1'b0;
					s_d.rd_more = 1'b0;
					s_d.phase = imbp_pkg::PH_DRIVE;
					if (s_q.target_address[imbp_pkg::BIT_DIR]) begin
						// Read request on an open bus turns the direction by a repeated start
						s_d.is_read = 1'b1;
						s_d.state = imbp_pkg::ST_START;
					end else begin
						s_d.state = imbp_pkg::ST_BIT;
						s_d.shift = s_q.transmit_byte;
						s_d.rx_mode = 1'b0;
						s_d.addr_phase = 1'b0;
						s_d.bitcnt = imbp_pkg::LAST_BIT;
					end
				end else if (s_q.rd_more && !s_q.rx_full_flag) begin
					// Next byte waits until software has taken the last one
					s_d.rd_more = 1'b0;
					s_d.state = imbp_pkg::ST_BIT;
					s_d.rx_mode = 1'b1;
					s_d.bitcnt = imbp_pkg::LAST_BIT;
					s_d.phase = imbp_pkg::PH_DRIVE;
				end
			end
			default: begin
			end
		endcase

		if (adv && !(s_q.state == imbp_pkg::ST_IDLE || s_q.state == imbp_pkg::ST_HOLD)) begin
			s_d.phase = s_q.phase + 2'h1;
			case (s_q.state)
				imbp_pkg::ST_START: begin
					case (s_q.phase)
						imbp_pkg::PH_DRIVE: s_d.sda_oe = 1'b0;
						imbp_pkg::PH_RISE: s_d.scl_oe = 1'b0;
						imbp_pkg::PH_SAMPLE: s_d.sda_oe = 1'b1;
						default: begin
							s_d.scl_oe = 1'b1;
							s_d.bus_open = 1'b1;
							s_d.state = imbp_pkg::ST_BIT;
							s_d.shift = s_q.target_address;
							s_d.rx_mode = 1'b0;
							s_d.addr_phase = 1'b1;
							s_d.bitcnt = imbp_pkg::LAST_BIT;
						end
					endcase
				end
				imbp_pkg::ST_BIT: begin
					case (s_q.phase)
						imbp_pkg::PH_DRIVE: s_d.sda_oe = s_q.rx_mode ? 1'b0 : ~s_q.shift[7];
						imbp_pkg::PH_RISE: s_d.scl_oe = 1'b0;
						imbp_pkg::PH_SAMPLE: s_d.shift = {s_q.shift[6:0], sda_hi};
						default: begin
							s_d.scl_oe = 1'b1;
							if (s_q.bitcnt == 3'h0) begin
								s_d.state = imbp_pkg::ST_ACK;
							end else begin
								s_d.bitcnt = s_q.bitcnt - 3'h1;
							end
						end
					endcase
				end
				imbp_pkg::ST_ACK: begin
					case (s_q.phase)
						imbp_pkg::PH_DRIVE: begin
							s_d.sda_oe = s_q.rx_mode ? ~s_q.stop_after_read : 1'b0;
							if (s_q.rx_mode) begin
								s_d.receive_byte = s_q.shift;
								s_d.rx_full_flag = 1'b1;
							end
						end
						imbp_pkg::PH_RISE: s_d.scl_oe = 1'b0;
						imbp_pkg::PH_SAMPLE: s_d.ack_fail = ~s_q.rx_mode & sda_hi;
						default: begin
							// Data line keeps its level here; moving it while the clock falls
							// could look like a stop to a target
							s_d.scl_oe = 1'b1;
							s_d.bitcnt = imbp_pkg::LAST_BIT;
							if (s_q.ack_fail) begin
								s_d.state = imbp_pkg::ST_STOP;
								s_d.err_pend = 1'b1;
							end else if (s_q.addr_phase) begin
								s_d.addr_phase = 1'b0;
								s_d.state = imbp_pkg::ST_BIT;
								s_d.rx_mode = s_q.is_read;
								s_d.shift = s_q.transmit_byte;
								// A read takes the transmit byte as a dummy, so it is empty now
								s_d.tx_empty_flag = s_q.tx_empty_flag | s_q.is_read;
							end else if (s_q.rx_mode) begin
								// Acknowledge driven in this slot decides whether the read goes on
								s_d.state = s_q.sda_oe ? imbp_pkg::ST_HOLD : imbp_pkg::ST_STOP;
								s_d.rd_more = s_q.sda_oe;
							end else begin
								s_d.tx_empty_flag = 1'b1;
								s_d.state = s_q.stop_after_write ? imbp_pkg::ST_STOP
									: imbp_pkg::ST_HOLD;
							end
						end
					endcase
				end
				imbp_pkg::ST_STOP: begin
					case (s_q.phase)
						imbp_pkg::PH_DRIVE: s_d.sda_oe = 1'b1;
						imbp_pkg::PH_RISE: s_d.scl_oe = 1'b0;
						imbp_pkg::PH_SAMPLE: s_d.scl_oe = 1'b0;
						default: begin
							s_d.sda_oe = 1'b0;
							s_d.bus_open = 1'b0;
							s_d.rd_more = 1'b0;
							s_d.state = imbp_pkg::ST_IDLE;
							if (s_q.err_pend) begin
								// Error shows only once the bus is free again
								s_d.err_pend = 1'b0;
								s_d.bus_error = 1'b1;
								s_d.tx_empty_flag = 1'b1;
							end
						end
					endcase
				end
				default: begin
					s_d.state = imbp_pkg::ST_IDLE;
				end
			endcase
		end

		s_d.tx_irq = s_q.tx_empty_flag & s_q.tx_empty_irq_enable;
		s_d.rx_irq = s_q.rx_full_flag & s_q.rx_ready_irq_enable;
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_q <= '0;
			s_q.state <= imbp_pkg::ST_IDLE;
			s_q.tx_empty_flag <= imbp_pkg::STATUS_RESET[imbp_pkg::BIT_TX_EMPTY];
			s_q.target_address <= imbp_pkg::ADDRESS_RESET;
			s_q.receive_byte <= imbp_pkg::RECEIVE_RESET;
			s_q.transmit_byte <= imbp_pkg::TRANSMIT_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata_out = s_q.rdata;
	assign tx_irq_out = s_q.tx_irq;
	assign rx_irq_out = s_q.rx_irq;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_out = s_q.scl_oe;
	assign sda_oe_out = s_q.sda_oe;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	stop_after_write_a: assert property (
		(s_q.state == imbp_pkg::ST_ACK && !s_q.rx_mode && !s_q.addr_phase && !s_q.ack_fail
			&& s_q.phase == imbp_pkg::PH_FALL && adv)
		|=> (s_q.state == ($past(s_q.stop_after_write) ? imbp_pkg::ST_STOP : imbp_pkg::ST_HOLD))
			&& s_q.tx_empty_flag)
		else $error("write byte end did not follow stop choice");

	stop_after_read_a: assert property (
		(s_q.state == imbp_pkg::ST_ACK && s_q.rx_mode && s_q.phase == imbp_pkg::PH_FALL && adv)
		|=> s_q.state == ($past(s_q.sda_oe) ? imbp_pkg::ST_HOLD : imbp_pkg::ST_STOP))
		else $error("read byte end did not follow acknowledge");

	tx_irq_gate_a: assert property (
		##1 tx_irq_out == $past(s_q.tx_empty_flag && s_q.tx_empty_irq_enable))
		else $error("transmit request not gated by its enable");

	rx_irq_gate_a: assert property (
		##1 rx_irq_out == $past(s_q.rx_full_flag && s_q.rx_ready_irq_enable))
		else $error("receive request not gated by its enable");

	tx_write_clear_a: assert property (
		(reg_wr_in && reg_addr_in == imbp_pkg::REG_TRANSMIT && s_q.state != imbp_pkg::ST_ACK
			&& s_q.state != imbp_pkg::ST_STOP)
		|=> !s_q.tx_empty_flag ##1 !s_q.tx_empty_flag)
		else $error("transmit write did not clear empty flag");

	error_keep_a: assert property (
		(s_q.bus_error && reg_wr_in && reg_addr_in == imbp_pkg::REG_STATUS
			&& !reg_wdata_in[imbp_pkg::BIT_ERROR])
		|=> s_q.bus_error)
		else $error("bus error lost on a zero write");

	error_after_stop_a: assert property (
		$rose(s_q.bus_error) |-> $past(s_q.state == imbp_pkg::ST_STOP) && !s_q.bus_open)
		else $error("bus error raised before the bus was freed");

	rx_read_clear_a: assert property (
		(reg_rd_in && reg_addr_in == imbp_pkg::REG_RECEIVE && s_q.state != imbp_pkg::ST_ACK)
		|=> !s_q.rx_full_flag && reg_rdata_out == $past(s_q.receive_byte))
		else $error("receive read did not clear full flag");

	rx_load_a: assert property (
		(s_q.state == imbp_pkg::ST_ACK && s_q.rx_mode && s_q.phase == imbp_pkg::PH_DRIVE && adv)
		|=> s_q.rx_full_flag && s_q.receive_byte == $past(s_q.shift))
		else $error("received byte not loaded with full flag");

	address_first_a: assert property (
		(s_q.state == imbp_pkg::ST_START && s_q.phase == imbp_pkg::PH_FALL && adv)
		|=> s_q.state == imbp_pkg::ST_BIT && s_q.shift == $past(s_q.target_address))
		else $error("address byte not loaded after start");

	transfer_start_a: assert property (
		(reg_wr_in && reg_addr_in == imbp_pkg::REG_TRANSMIT && s_q.state == imbp_pkg::ST_IDLE)
		|-> ##[1:2] s_q.state == imbp_pkg::ST_START)
		else $error("transmit write did not start a transfer");
endmodule : imbp_master
`default_nettype wire

//--- core/imbp_pkg.sv
// Constants, state codes and register layout of the byte-oriented two-wire master port
package imbp_pkg;

	localparam logic [1:0] REG_STATUS = 2'h0;
	localparam logic [1:0] REG_ADDRESS = 2'h1;
	localparam logic [1:0] REG_RECEIVE = 2'h2;
	localparam logic [1:0] REG_TRANSMIT = 2'h3;

	localparam int BIT_STOP_WR = 0;
	localparam int BIT_STOP_RD = 1;
	localparam int BIT_TX_IE = 2;
	localparam int BIT_TX_EMPTY = 3;
	localparam int BIT_FAST = 4;
	localparam int BIT_ERROR = 5;
	localparam int BIT_RX_IE = 6;
	localparam int BIT_RX_FULL = 7;
	localparam int BIT_DIR = 0;

	localparam logic [7:0] STATUS_RESET = 8'h08;
	localparam logic [7:0] ADDRESS_RESET = 8'h00;
	localparam logic [7:0] RECEIVE_RESET = 8'h00;
	localparam logic [7:0] TRANSMIT_RESET = 8'h00;

	localparam int REF_CLK_HZ = 10_000_000;
	localparam int STD_RATE_HZ = 100_000;
	localparam int FAST_RATE_HZ = 400_000;
	// Quarter bit periods round up so the bus never runs faster than its rate
	localparam int STD_QUARTER_CYC = (REF_CLK_HZ + 4 * STD_RATE_HZ - 1) / (4 * STD_RATE_HZ);
	localparam int FAST_QUARTER_CYC = (REF_CLK_HZ + 4 * FAST_RATE_HZ - 1) / (4 * FAST_RATE_HZ);
	localparam logic [7:0] STD_RELOAD = 8'(STD_QUARTER_CYC - 1);
	localparam logic [7:0] FAST_RELOAD = 8'(FAST_QUARTER_CYC - 1);

	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [1:0] PH_DRIVE = 2'h0;
	localparam logic [1:0] PH_RISE = 2'h1;
	localparam logic [1:0] PH_SAMPLE = 2'h2;
	localparam logic [1:0] PH_FALL = 2'h3;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_START = 6'h02,
		ST_BIT = 6'h04,
		ST_ACK = 6'h08,
		ST_STOP = 6'h10,
		ST_HOLD = 6'h20
	} imbp_state_t;

endpackage : imbp_pkg

//--- core/imbp_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module imbp_sync #(
	parameter int WIDTH = 2
) (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} imbp_sync_t;

	imbp_sync_t s_q;
	imbp_sync_t s_d;

	always_comb begin
		s_d.meta = async_in;
		s_d.stable = s_q.meta;
	end

	// Released bus lines idle high, so reset to ones
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_q <= '1;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_out = s_q.stable;
endmodule : imbp_sync
`default_nettype wire

//--- core/imbp_tick.sv
// Quarter-bit tick generator for the two bus rates
`timescale 1ns/1ps
`default_nettype none
module imbp_tick (
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic fast_in,
	output logic tick_out
);
	typedef struct packed {
		logic [7:0] count;
		logic tick;
	} imbp_tick_t;

	imbp_tick_t s_q;
	imbp_tick_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (s_q.count == 8'h00) begin
			s_d.count = fast_in ? imbp_pkg::FAST_RELOAD : imbp_pkg::STD_RELOAD;
			s_d.tick = 1'b1;
		end else begin
			s_d.count = s_q.count - 8'h01;
		end
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick_out = s_q.tick;
endmodule : imbp_tick
`default_nettype wire

//--- tb/imbp_target.sv
// Two-wire target model: acknowledges, records written bytes, answers reads
`timescale 1ns/1ps
`default_nettype none
module imbp_target (
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic ack_en_in,
	input wire logic [7:0] tx_byte_in,
	output logic sda_oe_out
);
	// Bit position within a byte; 99 means idle until the next start
	int bitn = 99;
	int n_start = 0;
	int n_stop = 0;
	time t0 = 0;
	time per = 0;
	logic rd = 1'b0;
	logic first = 1'b0;
	logic [7:0] sh = 8'h00;
	logic [7:0] got_q[$];
	initial sda_oe_out = 1'b0;
	always @(negedge sda_in) if (scl_in) begin
		n_start++;
		bitn = -1;
		first = 1'b1;
		rd = 1'b0;
	end
	always @(posedge sda_in) if (scl_in) begin
		n_stop++;
		bitn = 99;
		sda_oe_out = 1'b0;
	end
	always @(posedge scl_in) begin
		if (bitn == 0) t0 = $time;
		if (bitn == 1) per = $time - t0;
		if (bitn >= 0 && bitn < 8) sh = {sh[6:0], sda_in};
		// A high level in the acknowledge slot ends the read
		if (bitn == 8 && rd && sda_in) bitn = 99;
	end
	// Data is changed only while the clock is low, so start and stop stay unique
	always @(negedge scl_in) if (bitn < 9) begin
		bitn++;
		if (bitn == 9) bitn = 0;
		if (bitn == 8 && !rd) begin
			got_q.push_back(sh);
			sda_oe_out = ack_en_in;
			if (first) rd = sh[0] & ack_en_in;
			first = 1'b0;
		end else begin
			sda_oe_out = rd && bitn < 8 && !tx_byte_in[7 - bitn];
		end
	end
endmodule : imbp_target
`default_nettype wire

//--- tb/imbp_master_test.sv
// Self-checking bench for the two-wire master port
`timescale 1ns/1ps
`default_nettype none
module imbp_master_test;
	logic ref_clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [1:0] reg_addr_in = 2'h0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [7:0] reg_rdata_out;
	logic tx_irq_out, rx_irq_out, scl_out, scl_oe_out, sda_out, sda_oe_out, t_oe;
	logic ack_en = 1'b1;
	logic irq_t, irq_r;
	logic [7:0] t_byte = 8'h00;
	logic [7:0] q[$];
	logic [31:0] seed = 32'h0A36B235;
	int n_mismatch = 0;
	int tests_run = 0;
	// Open-drain lines with pull-ups
	wire logic scl_w = !scl_oe_out;
	wire logic sda_w = !(sda_oe_out | t_oe);

	imbp_master u_imbp_master (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .tx_irq_out(tx_irq_out),
		.rx_irq_out(rx_irq_out), .scl_in(scl_w), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out));
	imbp_target u_imbp_target (.scl_in(scl_w), .sda_in(sda_w), .ack_en_in(ack_en),
		.tx_byte_in(t_byte), .sda_oe_out(t_oe));

	initial forever #50 ref_clk_in = ~ref_clk_in;

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd

	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Idle cycle after each write keeps the strobe from being driven twice in one step
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
		@(posedge ref_clk_in);
	endtask : wr

	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		#1;
		v = reg_rdata_out;
		irq_t = tx_irq_out;
		irq_r = rx_irq_out;
		@(posedge ref_clk_in);
	endtask : rd

	task automatic wait_st(input int b, input logic v);
		logic [7:0] s;
		for (int i = 0; i < 4000; i++) begin
			rd(2'h0, s);
			if (s[b] === v) return;
		end
		$display("ERROR t=%0t status %h waiting bit %h", $time, s, b);
		n_mismatch++;
		finish_test();
	endtask : wait_st

	task automatic wait_stop(input int n);
		for (int i = 0; i < 400; i++) begin
			if (u_imbp_target.n_stop != n) return;
			@(posedge ref_clk_in);
		end
		$display("ERROR t=%0t stops %h expected above %h", $time, u_imbp_target.n_stop, n);
		n_mismatch++;
		finish_test();
	endtask : wait_stop

	task automatic send(input logic [7:0] v);
		logic [7:0] s;
		wr(2'h3, v);
		rd(2'h0, s);
		chk(s[3], 1'b0);
		wait_st(3, 1'b1);
	endtask : send

	task automatic cmpq();
		chk(u_imbp_target.got_q.size(), q.size());
		foreach (q[i]) chk(u_imbp_target.got_q[i], q[i]);
		u_imbp_target.got_q.delete();
		q.delete();
	endtask : cmpq

	initial begin
		logic [7:0] s;
		logic [7:0] a7;
		int ns;
		int nst;
		repeat (4) @(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		@(posedge ref_clk_in);
		rd(2'h0, s);
		chk(s, 8'h08);
		rd(2'h2, s);
		chk(s, 8'h00);
		wr(2'h0, 8'h05);
		rd(2'h0, s);
		chk(s, 8'h0D);
		chk(irq_t, 1'b1);
		// Single byte write at the slow rate with a stop
		a7 = rnd() & 8'hFE;
		q = '{a7, rnd()};
		wr(2'h1, a7);
		ns = u_imbp_target.n_stop;
		send(q[1]);
		cmpq();
		wait_stop(ns);
		chk(u_imbp_target.n_stop, ns + 1);
		chk(32'(u_imbp_target.per), 32'd10000);
		// Dummy write then current-address read at the fast rate
		wr(2'h0, 8'h10);
		rd(2'h0, s);
		chk(irq_t, 1'b0);
		wr(2'h1, a7);
		ns = u_imbp_target.n_stop;
		q = '{a7, rnd(), rnd(), a7 | 8'h01};
		send(q[1]);
		send(q[2]);
		chk(u_imbp_target.n_stop, ns);
		chk(32'(u_imbp_target.per), 32'd2800);
		wr(2'h0, 8'h52);
		wr(2'h1, q[3]);
		t_byte <= rnd();
		nst = u_imbp_target.n_start;
		wr(2'h3, rnd());
		wait_st(7, 1'b1);
		rd(2'h0, s);
		chk(irq_r, 1'b1);
		chk(s[3], 1'b1);
		wr(2'h2, 8'hFF);
		rd(2'h2, s);
		chk(s, t_byte);
		rd(2'h0, s);
		chk(s[7], 1'b0);
		wait_stop(ns);
		chk(u_imbp_target.n_stop, ns + 1);
		chk(u_imbp_target.n_start, nst + 1);
		cmpq();
		// Two-byte read: acknowledge the first byte, stop after the second
		ns = u_imbp_target.n_stop;
		q = '{a7 | 8'h01};
		wr(2'h0, 8'h50);
		wr(2'h3, rnd());
		for (int k = 0; k < 2; k++) begin
			wait_st(7, 1'b1);
			if (k == 0) wr(2'h0, 8'h52);
			rd(2'h2, s);
			chk(s, t_byte);
		end
		wait_stop(ns);
		chk(u_imbp_target.n_stop, ns + 1);
		cmpq();
		// Target stays silent: stop first, then error flag
		ack_en <= 1'b0;
		wr(2'h0, 8'h11);
		wr(2'h1, a7);
		q = '{a7};
		ns = u_imbp_target.n_stop;
		send(rnd());
		cmpq();
		chk(u_imbp_target.n_stop, ns + 1);
		rd(2'h0, s);
		chk(s & 8'h20, 8'h20);
		wr(2'h0, 8'h11);
		rd(2'h0, s);
		chk(s & 8'h20, 8'h20);
		wr(2'h0, 8'h31);
		rd(2'h0, s);
		chk(s, 8'h19);
		finish_test();
	end
endmodule : imbp_master_test
`default_nettype wire
